// [rtl/od_pkg.sv]
package od_pkg;

  // =====================================================
  // object addressing
  localparam int index_w = 16;
  localparam int subindex_w = 8;
  localparam int history_depth = 10;

  localparam logic [15:0] idx_device_profile_id = 16'h1000;
  localparam logic [15:0] idx_error_summary = 16'h1001;
  localparam logic [15:0] idx_vendor_status_word = 16'h1002;
  localparam logic [15:0] idx_error_history = 16'h1003;
  localparam logic [15:0] idx_sync_message_identifier = 16'h1005;
  localparam logic [15:0] idx_sync_cycle_period = 16'h1006;
  localparam logic [15:0] idx_sync_window_length = 16'h1007;

  // =====================================================
  // index areas
  localparam logic [15:0] area_reserved_low_lo = 16'h00a0;
  localparam logic [15:0] area_comm_lo = 16'h1000;
  localparam logic [15:0] area_comm_hi = 16'h1fff;
  localparam logic [15:0] area_vendor_lo = 16'h2000;
  localparam logic [15:0] area_vendor_hi = 16'h5fff;
  localparam logic [15:0] area_profile_lo = 16'h6000;
  localparam logic [15:0] area_profile_hi = 16'h9fff;
  localparam logic [15:0] group_vendor_lo = 16'h4000;
  localparam logic [15:0] group_vendor_hi = 16'h4fff;
  localparam logic [15:0] group_profile_lo = 16'h6000;
  localparam logic [15:0] group_profile_hi = 16'h6fff;

  typedef enum logic [2:0] {
    area_static = 3'h0,
    area_reserved = 3'h1,
    area_comm = 3'h2,
    area_vendor = 3'h3,
    area_profile = 3'h4
  } area_t;

  // =====================================================
  // object, data and access codes
  typedef enum logic [7:0] {
    obj_var = 8'h07,
    obj_array = 8'h08,
    obj_record = 8'h09
  } obj_code_t;

  typedef enum logic [15:0] {
    dt_none = 16'h0000,
    dt_bool = 16'h0001,
    dt_int8 = 16'h0002,
    dt_int16 = 16'h0003,
    dt_int32 = 16'h0004,
    dt_uint8 = 16'h0005,
    dt_uint16 = 16'h0006,
    dt_uint32 = 16'h0007,
    dt_string8 = 16'h0009
  } data_code_t;

  typedef enum logic [1:0] {
    acc_ro = 2'h0,
    acc_rw = 2'h1,
    acc_rww = 2'h2,
    acc_const = 2'h3
  } access_t;

  // =====================================================
  // factory values
  localparam logic [31:0] device_profile_id_value = 32'h0001_2345; // arbitrary
  localparam logic [7:0] error_history_count_reset = 8'h00;
  localparam logic [31:0] sync_message_identifier_reset = 32'h0000_0080;
  localparam logic [31:0] sync_cycle_period_reset = 32'h0000_0000;
  localparam logic [31:0] sync_window_length_reset = 32'h0000_0000;
  localparam logic [31:0] error_entry_reset = 32'h0000_0000;
  localparam logic [7:0] count_max = 8'h0a;

  // =====================================================
  // service answer codes
  typedef enum logic [1:0] {
    ans_ok = 2'h0,
    ans_no_object = 2'h1,
    ans_read_only = 2'h2,
    ans_out_of_range = 2'h3
  } answer_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] index;
    logic [7:0] subindex;
    logic [31:0] data;
  } od_request_t;

  typedef struct packed {
    logic valid;
    answer_t code;
    logic [31:0] data;
    obj_code_t obj_code;
    data_code_t data_code;
    access_t access;
    logic mappable;
    area_t area;
  } od_answer_t;

endpackage

// [rtl/canopen_comm_object_dictionary.sv]
`timescale 1ns/1ps
module canopen_comm_object_dictionary
  import od_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // service data requests from the protocol engine
  input wire od_request_t request,
  output od_answer_t answer,
  // error events reported by the drive
  input wire logic error_event,
  input wire logic [31:0] error_code,
  // live device state
  input wire logic [7:0] error_summary,
  input wire logic [31:0] vendor_status_word,
  // configuration driven into the rest of the node
  output logic [31:0] sync_message_identifier,
  output logic [31:0] sync_cycle_period,
  output logic [31:0] sync_window_length,
  output logic [7:0] error_history_count
);

  // =====================================================
  // error history storage
  logic [31:0] error_history [history_depth];
  logic clear_history;
  logic [7:0] next_count;

  // a new error in the same cycle as a clear survives as the only entry
  always_comb
  begin
    if (clear_history)
      next_count = error_event ? 8'h01 : 8'h00;
    else if (error_event && error_history_count != count_max)
      next_count = error_history_count + 8'h01;
    else
      next_count = error_history_count;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      error_history_count <= error_history_count_reset;
    else
      error_history_count <= next_count;
  end

  genvar g;
  generate
    for (g = 0; g < history_depth; g++)
    begin : hist
      always_ff @(posedge clk)
      begin
        if (rst)
          error_history[g] <= error_entry_reset;
        else if (error_event)
        begin
          if (g == 0)
            error_history[g] <= error_code;
          else if (clear_history)
            error_history[g] <= error_entry_reset;
          else
            error_history[g] <= error_history[g-1];
        end
        else if (clear_history)
          error_history[g] <= error_entry_reset;
      end
    end
  endgenerate

  // =====================================================
  // index area classification
  area_t req_area;
  logic populated;

  always_comb
  begin
    if (request.index >= area_comm_lo && request.index <= area_comm_hi)
      req_area = area_comm;
    else if (request.index >= area_vendor_lo && request.index <= area_vendor_hi)
      req_area = area_vendor;
    else if (request.index >= area_profile_lo && request.index <= area_profile_hi)
      req_area = area_profile;
    else if (request.index >= area_reserved_low_lo)
      req_area = area_reserved;
    else
      req_area = area_static;
  end

  // vendor and profile groups live elsewhere; only the comm group answers here
  assign populated = (req_area == area_comm)
    || (request.index >= group_vendor_lo && request.index <= group_vendor_hi)
    || (request.index >= group_profile_lo && request.index <= group_profile_hi);

  // =====================================================
  // object decode
  logic hit;
  logic [31:0] rd_data;
  obj_code_t rd_obj;
  data_code_t rd_type;
  access_t rd_acc;
  logic has_bounds;
  logic [31:0] min_value;
  logic [31:0] max_value;

  always_comb
  begin
    hit = 1'b1;
    rd_data = 32'h0000_0000;
    rd_obj = obj_var;
    rd_type = dt_uint32;
    rd_acc = acc_ro;
    has_bounds = 1'b0;
    min_value = 32'h0000_0000;
    max_value = 32'hffff_ffff;
    if (request.index == idx_device_profile_id && request.subindex == 8'h00)
      rd_data = device_profile_id_value;
    else if (request.index == idx_error_summary && request.subindex == 8'h00)
    begin
      rd_data = {24'h000000, error_summary};
      rd_type = dt_uint8;
    end
    else if (request.index == idx_vendor_status_word && request.subindex == 8'h00)
      rd_data = vendor_status_word;
    else if (request.index == idx_error_history && request.subindex == 8'h00)
    begin
      rd_data = {24'h000000, error_history_count};
      rd_type = dt_uint8;
      rd_acc = acc_rw;
      has_bounds = 1'b1; // only the clear value is accepted
      max_value = 32'h0000_0000;
    end
    else if (request.index == idx_error_history && request.subindex >= 8'h01
             && request.subindex <= count_max)
      rd_data = error_history[request.subindex[3:0] - 4'h1];
    else if (request.index == idx_sync_message_identifier && request.subindex == 8'h00)
    begin
      rd_data = sync_message_identifier;
      rd_acc = acc_rw;
    end
    else if (request.index == idx_sync_cycle_period && request.subindex == 8'h00)
    begin
      rd_data = sync_cycle_period;
      rd_acc = acc_rw;
    end
    else if (request.index == idx_sync_window_length && request.subindex == 8'h00)
    begin
      rd_data = sync_window_length;
      rd_acc = acc_rw;
    end
    else
      hit = 1'b0;
    // only the history count entry (subindex 0) reports as an array; its entries report as variables
    if (request.index == idx_error_history && request.subindex == 8'h00)
      rd_obj = obj_array;
  end

  // =====================================================
  // write checking
  logic writable;
  logic in_range;
  logic accept_write;

  assign writable = (rd_acc == acc_rw) || (rd_acc == acc_rww);
  assign in_range = !has_bounds
    || (request.data >= min_value && request.data <= max_value);
  assign accept_write = request.valid && request.write && hit && writable && in_range;
  assign clear_history = accept_write && request.index == idx_error_history;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_message_identifier <= sync_message_identifier_reset;
      sync_cycle_period <= sync_cycle_period_reset;
      sync_window_length <= sync_window_length_reset;
    end
    else if (accept_write)
    begin
      if (request.index == idx_sync_message_identifier)
        sync_message_identifier <= request.data;
      else if (request.index == idx_sync_cycle_period)
        sync_cycle_period <= request.data;
      else if (request.index == idx_sync_window_length)
        sync_window_length <= request.data;
    end
  end

  // =====================================================
  // answer, one cycle after each request
  answer_t next_code;

  always_comb
  begin
    if (!hit)
      next_code = ans_no_object;
    else if (request.write && !writable)
      next_code = ans_read_only;
    else if (request.write && !in_range)
      next_code = ans_out_of_range;
    else
      next_code = ans_ok;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      answer <= '0;
    else
    begin
      answer.valid <= request.valid;
      answer.code <= next_code;
      answer.data <= (request.valid && !request.write && hit) ? rd_data : 32'h0000_0000;
      answer.obj_code <= rd_obj;
      answer.data_code <= hit ? rd_type : dt_none;
      answer.access <= rd_acc;
      answer.mappable <= 1'b0; // none of these objects map
      answer.area <= req_area;
    end
  end

  // unreferenced until the populated groups get their own storage
  logic unused_populated;
  assign unused_populated = populated;

endmodule

// [tb/od_checker.sv]
`timescale 1ns/1ps
module od_checker
  import od_pkg::*;
(
  // watched ports
  input wire logic clk,
  input wire logic rst,
  input wire od_request_t request,
  input wire od_answer_t answer,
  input wire logic error_event,
  input wire logic [31:0] error_code,
  input wire logic [7:0] error_summary,
  input wire logic [31:0] vendor_status_word,
  input wire logic [31:0] sync_message_identifier,
  input wire logic [31:0] sync_cycle_period,
  input wire logic [31:0] sync_window_length,
  input wire logic [7:0] error_history_count
);
  // ==========
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire wr = request.valid && request.write;
  wire cnt_wr = wr && request.index == idx_error_history && request.subindex == 8'h00;
  wire [7:0] cnt = error_history_count;
  sequence s_req;
    request.valid;
  endsequence
  sequence s_ans;
    answer.valid;
  endsequence
  property p_answer;
    s_req |=> s_ans;
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered");
  property p_mappable;
    s_ans |-> !answer.mappable;
  endproperty
  a_mappable: assert property (p_mappable)
    else $error("mappable set");
  property p_count_max;
    cnt <= count_max;
  endproperty
  a_count_max: assert property (p_count_max)
    else $error("count above ten");
  property p_clear;
    cnt_wr && request.data == 32'h0 && !error_event |=> cnt == 8'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("history not cleared");
  property p_push;
    error_event && !cnt_wr |=> cnt == ($past(cnt) == count_max ? count_max : $past(cnt) + 8'h01);
  endproperty
  a_push: assert property (p_push)
    else $error("count step wrong");
  property p_ro;
    wr && request.index == idx_device_profile_id && request.subindex == 8'h00
      |=> answer.code == ans_read_only;
  endproperty
  a_ro: assert property (p_ro)
    else $error("read only write taken");
  // a nonzero count write must leave the count alone
  property p_range;
    cnt_wr && request.data != 32'h0 && !error_event |=> answer.code == ans_out_of_range && $stable(cnt);
  endproperty
  a_range: assert property (p_range)
    else $error("range write taken");
  property p_none;
    request.valid && request.index == 16'ha000 |=> answer.code == ans_no_object;
  endproperty
  a_none: assert property (p_none)
    else $error("reserved index answered");
  property p_area;
    request.valid && request.index == 16'ha000 |=> answer.area == area_reserved;
  endproperty
  a_area: assert property (p_area)
    else $error("reserved index misclassified");
  // the count entry reports the array object code and the unsigned byte data type
  property p_obj;
    request.valid && request.index == idx_error_history && request.subindex == 8'h00
      |=> answer.obj_code == obj_array && answer.data_code == dt_uint8;
  endproperty
  a_obj: assert property (p_obj)
    else $error("count entry type wrong");
  property p_period;
    wr && request.index == idx_sync_cycle_period && request.subindex == 8'h00
      |=> sync_cycle_period == $past(request.data);
  endproperty
  a_period: assert property (p_period)
    else $error("cycle period write lost");
endmodule
bind canopen_comm_object_dictionary od_checker od_checker_inst (.clk(clk), .rst(rst),
  .request(request), .answer(answer), .error_event(error_event), .error_code(error_code),
  .error_summary(error_summary), .vendor_status_word(vendor_status_word),
  .sync_message_identifier(sync_message_identifier), .sync_cycle_period(sync_cycle_period),
  .sync_window_length(sync_window_length), .error_history_count(error_history_count));

// [tb/sdo_client.sv]
`timescale 1ns/1ps
module sdo_client
  import od_pkg::*;
(
  // service link
  input wire logic clk,
  output od_request_t request
);
  initial request = '0;
  // ==========
  // one request per call, then the fields are scrambled
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d);
    @(negedge clk);
    request = '{1'b1, w, i, s, d};
    @(negedge clk);
    request = '{1'b0, ~w, ~i, ~s, ~d};
  endtask
endmodule

// [tb/canopen_comm_object_dictionary_bench.sv]
`timescale 1ns/1ps
module canopen_comm_object_dictionary_bench;
  import od_pkg::*;
  logic clk, rst, error_event;
  logic [31:0] error_code, vendor_status_word, sync_message_identifier, sync_cycle_period, d;
  logic [31:0] sync_window_length;
  logic [7:0] error_summary, error_history_count;
  od_request_t request;
  od_answer_t answer;
  logic [33:0] exp_q[$];
  logic [31:0] hist[$];
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  canopen_comm_object_dictionary canopen_comm_object_dictionary_inst (.clk(clk), .rst(rst),
    .request(request), .answer(answer), .error_event(error_event), .error_code(error_code),
    .error_summary(error_summary), .vendor_status_word(vendor_status_word),
    .sync_message_identifier(sync_message_identifier), .sync_cycle_period(sync_cycle_period),
    .sync_window_length(sync_window_length), .error_history_count(error_history_count));
  sdo_client sdo_client_inst (.clk(clk), .request(request));
  // ==========
  // tasks
  task automatic cmp(input string what, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic op(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] dt, input answer_t c, input logic [31:0] r);
    exp_q.push_back({c, r});
    sdo_client_inst.xfer(w, i, s, dt);
  endtask
  task automatic err(input logic [31:0] c);
    @(negedge clk);
    error_event = 1'b1;
    error_code = c;
    @(negedge clk);
    error_event = 1'b0;
    hist.push_front(c);
  endtask
  task automatic summarize;
    if (exp_q.size() != 0)
      err_count++;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========
  // clock, watchdog and answer monitor
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // sampled mid-cycle so the registered answer has settled
  always @(negedge clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      err_count++;
      summarize();
    end
    if (!rst && answer.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        cmp("answer count", 34'h0, 34'h1);
      else
        cmp("answer", exp_q.pop_front(), {answer.code, answer.data});
    end
  end
  // ==========
  // stimulus
  initial
  begin
    rst = 1'b1;
    error_event = 1'b0;
    error_code = 32'h0;
    d = $urandom(66);
    error_summary = $urandom;
    vendor_status_word = $urandom;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    op(0, idx_sync_message_identifier, 0, 0, ans_ok, sync_message_identifier_reset);
    op(0, idx_sync_window_length, 0, 0, ans_ok, 32'h0);
    op(0, idx_error_history, 0, 0, ans_ok, 32'h0);
    op(0, idx_device_profile_id, 0, 0, ans_ok, device_profile_id_value);
    op(0, idx_error_summary, 0, 0, ans_ok, {24'h0, error_summary});
    op(0, idx_vendor_status_word, 0, 0, ans_ok, vendor_status_word);
    for (int k = 5; k < 8; k++)
    begin
      d = $urandom;
      op(1, 16'h1000 + 16'(k), 0, d, ans_ok, 32'h0);
      op(0, 16'h1000 + 16'(k), 0, 0, ans_ok, d);
    end
    cmp("window port", {2'b0, d}, {2'b0, sync_window_length});
    op(1, idx_device_profile_id, 0, $urandom, ans_read_only, 32'h0);
    op(1, idx_error_history, 8'h01, 1, ans_read_only, 32'h0);
    op(1, idx_error_history, 0, 5, ans_out_of_range, 32'h0);
    op(0, 16'h2000, 0, 0, ans_no_object, 32'h0);
    op(0, 16'ha000, 0, 0, ans_no_object, 32'h0);
    op(0, idx_error_history, 8'h0b, 0, ans_no_object, 32'h0);
    repeat (11) err($urandom);
    cmp("count port", 34'h0a, {26'h0, error_history_count});
    op(0, idx_error_history, 0, 0, ans_ok, 32'h0a);
    op(0, idx_error_history, 8'h01, 0, ans_ok, hist[0]);
    op(0, idx_error_history, 8'h0a, 0, ans_ok, hist[9]);
    op(1, idx_error_history, 0, 0, ans_ok, 32'h0);
    cmp("cleared count", 34'h0, {26'h0, error_history_count});
    op(0, idx_error_history, 8'h01, 0, ans_ok, 32'h0);
    repeat (3) @(negedge clk);
    summarize();
  end
endmodule
